// ---- rtl/tcc_channels.sv ----
// Four capture/compare channels with their status/control and value registers.
// Assumes an external counter giving its value, timer tick, overflow pulse and halt.
`timescale 1ns/1ps
// How it works
// R1 - Capture edge select: 01 rising, 10 falling, 11 either edge.
// R2 - Unbuffered compare action: 00 none, 01 toggle, 10 clear, 11 set.
// R3 - Buffered mode gives the same toggle, clear and set actions on match.
// R4 - Edge/level 00 releases the pin; low mode bit presets output, 0 high, 1 low.
// R5 - Released channel keeps its level and drives it once operation is enabled.
// R6 - Reset clears edge/level bits, so every pin starts released.
// R7 - Overflow toggle bit toggles compare output on each overflow; ignored in capture.
// R8 - Overflow toggle wins over a compare action in the same cycle.
// R9 - Overflow toggle, clear on compare and max duty force full duty.
// R10 - Max duty changes act from the next period after the write.
// R11 - Each channel has an unreset 16-bit capture or compare value.
// R12 - Reading high byte in capture mode blocks captures until low byte read.
// R13 - Writing high byte in compare mode blocks matches until low byte written.
// R14 - Pin should be stable two bus clocks before capture is enabled.
// R15 - Flag sets on an active capture edge or a compare match.
// R16 - Buffered mode on channel 0 or 2 disables channel 1 or 3.
// R17 - Counter halt inhibits all captures until it clears.
// R18 - Overflow pulse marks counter reaching modulo and the PWM period edge.
// R19 - Buffered pair switches to the last written value at overflow.
module tcc_channels
  import tcc_pkg::*;
(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_clk_en,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] i_axi_awaddr,
  input  wire logic              i_axi_awvalid,
  output logic                   o_axi_awready,
  input  wire logic [31:0]       i_axi_wdata,
  input  wire logic [3:0]        i_axi_wstrb,
  input  wire logic              i_axi_wvalid,
  output logic                   o_axi_wready,
  output logic [1:0]             o_axi_bresp,
  output logic                   o_axi_bvalid,
  input  wire logic              i_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] i_axi_araddr,
  input  wire logic              i_axi_arvalid,
  output logic                   o_axi_arready,
  output logic [31:0]            o_axi_rdata,
  output logic [1:0]             o_axi_rresp,
  output logic                   o_axi_rvalid,
  input  wire logic              i_axi_rready,
  // Shared counter
  input  wire logic [VAL_W-1:0]  i_counter,
  input  wire logic              i_tclk_en,
  input  wire logic              i_overflow,
  input  wire logic              i_counter_halt,
  // Channel pins
  input  wire logic [NUM_CH-1:0] i_channel_pin,
  output logic [NUM_CH-1:0]      o_channel_pin,
  output logic [NUM_CH-1:0]      o_channel_pin_oe,
  output logic [NUM_CH-1:0]      o_channel_event_flag
);
  tcc_reg_if regs ();

  tcc_axil_slave u_slave (
    .i_sys_clk     (i_sys_clk),
    .i_nrst        (i_nrst),
    .i_clk_en      (i_clk_en),
    .i_axi_awaddr  (i_axi_awaddr),
    .i_axi_awvalid (i_axi_awvalid),
    .o_axi_awready (o_axi_awready),
    .i_axi_wdata   (i_axi_wdata),
    .i_axi_wstrb   (i_axi_wstrb),
    .i_axi_wvalid  (i_axi_wvalid),
    .o_axi_wready  (o_axi_wready),
    .o_axi_bresp   (o_axi_bresp),
    .o_axi_bvalid  (o_axi_bvalid),
    .i_axi_bready  (i_axi_bready),
    .i_axi_araddr  (i_axi_araddr),
    .i_axi_arvalid (i_axi_arvalid),
    .o_axi_arready (o_axi_arready),
    .o_axi_rdata   (o_axi_rdata),
    .o_axi_rresp   (o_axi_rresp),
    .o_axi_rvalid  (o_axi_rvalid),
    .i_axi_rready  (i_axi_rready),
    .regs          (regs)
  );

  logic [6:0]       sc_reg      [NUM_CH];
  logic [VAL_W-1:0] val_reg     [NUM_CH];
  logic [NUM_CH-1:0] flag_reg;
  logic [NUM_CH-1:0] armed_reg;
  logic [NUM_CH-1:0] cap_block_reg;
  logic [NUM_CH-1:0] cmp_block_reg;
  logic [NUM_CH-1:0] out_reg;
  logic [NUM_CH-1:0] oe_reg;
  logic [NUM_CH-1:0] max_eff_reg;
  logic [1:0]        last_wr_reg;
  logic [1:0]        act_sel_reg;

  logic [6:0]       cfg         [NUM_CH];
  logic [VAL_W-1:0] cmp_val     [NUM_CH];
  logic [1:0]       els         [NUM_CH];
  logic [NUM_CH-1:0] dis;
  logic [NUM_CH-1:0] capture;
  logic [NUM_CH-1:0] compare;
  logic [NUM_CH-1:0] rise;
  logic [NUM_CH-1:0] fall;
  logic [NUM_CH-1:0] cap_hit;
  logic [NUM_CH-1:0] match;
  logic [NUM_CH-1:0] evt;
  logic [NUM_CH-1:0] ovf_act;
  logic [NUM_CH-1:0] wr_sc;
  logic [NUM_CH-1:0] wr_vh;
  logic [NUM_CH-1:0] wr_vl;
  logic [NUM_CH-1:0] rd_sc;
  logic [NUM_CH-1:0] rd_vh;
  logic [NUM_CH-1:0] rd_vl;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_edge
    tcc_edge_detect u_edge (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .i_clk_en  (i_clk_en),
      .i_level   (i_channel_pin[g]),
      .o_rise    (rise[g]),
      .o_fall    (fall[g])
    );
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      wr_sc[c] = regs.wr && ch_of(regs.waddr) == 2'(c) && off_of(regs.waddr) == OFF_STATUS_CTRL;
      wr_vh[c] = regs.wr && ch_of(regs.waddr) == 2'(c) && off_of(regs.waddr) == OFF_VALUE_HIGH;
      wr_vl[c] = regs.wr && ch_of(regs.waddr) == 2'(c) && off_of(regs.waddr) == OFF_VALUE_LOW;
      rd_sc[c] = regs.rd && ch_of(regs.raddr) == 2'(c) && off_of(regs.raddr) == OFF_STATUS_CTRL;
      rd_vh[c] = regs.rd && ch_of(regs.raddr) == 2'(c) && off_of(regs.raddr) == OFF_VALUE_HIGH;
      rd_vl[c] = regs.rd && ch_of(regs.raddr) == 2'(c) && off_of(regs.raddr) == OFF_VALUE_LOW;
      // Odd channel of a buffered pair loses its status/control register and its pin
      dis[c]     = (c % 2 == 1) && sc_reg[c & 2][BIT_BUF]; // R16
      cfg[c]     = dis[c] ? SC_RESET : sc_reg[c];
      els[c]     = cfg[c][BIT_ELH:BIT_ELL];
      capture[c] = !cfg[c][BIT_BUF] && !cfg[c][BIT_UNB] && els[c] != ELS_RELEASE;
      compare[c] = cfg[c][BIT_BUF] || cfg[c][BIT_UNB];
      // Buffered channel compares against whichever pair member is active
      cmp_val[c] = cfg[c][BIT_BUF] ? val_reg[(c & 2) + int'(act_sel_reg[c / 2])]
                                   : val_reg[c]; // R3 R19
      match[c]   = compare[c] && i_tclk_en && i_counter == cmp_val[c] &&
                   !cmp_block_reg[c] &&
                   !(cfg[c][BIT_BUF] && cmp_block_reg[c | 1]); // R13
      cap_hit[c] = capture[c] && !i_counter_halt && !cap_block_reg[c] && // R17 R12
                   ((els[c][0] && rise[c]) || (els[c][1] && fall[c])); // R1
      evt[c]     = cap_hit[c] || match[c]; // R15
      ovf_act[c] = compare[c] && cfg[c][BIT_TOV] && i_overflow; // R7 R18
    end
  end

  // Status/control bits; reset leaves every pin released
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        sc_reg[c] <= SC_RESET; // R6
      end
    end else if (i_clk_en) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (wr_sc[c] && !dis[c]) begin
          sc_reg[c] <= (c % 2 == 1) ? (regs.wdata[6:0] & ~(7'h01 << BIT_BUF))
                                    : regs.wdata[6:0]; // R16
        end
      end
    end
  end

  // Flag clears by reading it set and then writing 0; a new event always wins
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flag_reg  <= '0;
      armed_reg <= '0;
    end else if (i_clk_en) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (evt[c]) begin
          flag_reg[c] <= 1'b1; // R15
        end else if (wr_sc[c] && !dis[c] && !regs.wdata[BIT_FLAG] && armed_reg[c]) begin
          flag_reg[c] <= 1'b0;
        end
        if (evt[c] || wr_sc[c]) begin
          armed_reg[c] <= 1'b0;
        end else if (rd_sc[c] && flag_reg[c]) begin
          armed_reg[c] <= 1'b1;
        end
      end
    end
  end

  // Value registers carry no reset; a capture overrides a same-cycle write
  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (cap_hit[c]) begin
          val_reg[c] <= i_counter; // R11
        end else if (wr_vh[c]) begin
          val_reg[c][15:8] <= regs.wdata;
        end else if (wr_vl[c]) begin
          val_reg[c][7:0] <= regs.wdata;
        end
      end
    end
  end

  // Byte access interlocks
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cap_block_reg <= '0;
      cmp_block_reg <= '0;
    end else if (i_clk_en) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (rd_vl[c]) begin
          cap_block_reg[c] <= 1'b0;
        end else if (rd_vh[c] && capture[c]) begin
          cap_block_reg[c] <= 1'b1; // R12
        end
        if (wr_vl[c]) begin
          cmp_block_reg[c] <= 1'b0;
        end else if (wr_vh[c] && (compare[c] || compare[c & 2])) begin
          cmp_block_reg[c] <= 1'b1; // R13
        end
      end
    end
  end

  // Buffered pairs: the write target is remembered, taken over at overflow
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      last_wr_reg <= 2'h0;
      act_sel_reg <= 2'h0;
    end else if (i_clk_en) begin
      for (int p = 0; p < NUM_CH / 2; p++) begin
        if (wr_vl[2 * p]) begin
          last_wr_reg[p] <= 1'b0;
        end else if (wr_vl[2 * p + 1]) begin
          last_wr_reg[p] <= 1'b1;
        end
        if (i_overflow) begin
          act_sel_reg[p] <= last_wr_reg[p]; // R19
        end
      end
    end
  end

  // Max duty is sampled only at the period edge, so a change acts next period
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      max_eff_reg <= '0;
    end else if (i_clk_en) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (i_overflow) begin
          max_eff_reg[c] <= cfg[c][BIT_MAX]; // R10
        end
      end
    end
  end

  // Channel output level
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_reg <= '1;
    end else if (i_clk_en) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (els[c] == ELS_RELEASE) begin
          out_reg[c] <= !cfg[c][BIT_UNB]; // R4
        end else if (ovf_act[c]) begin
          if (max_eff_reg[c] && els[c] == ELS_FALL_CLR) begin
            out_reg[c] <= 1'b1; // R9
          end else begin
            out_reg[c] <= !out_reg[c]; // R7 R8
          end
        end else if (match[c]) begin
          case (els[c])
            ELS_RISE_TGL: out_reg[c] <= !out_reg[c]; // R2
            ELS_FALL_CLR: out_reg[c] <= max_eff_reg[c] && cfg[c][BIT_TOV]; // R2 R9
            ELS_ANY_SET:  out_reg[c] <= 1'b1; // R2
            default:      out_reg[c] <= out_reg[c];
          endcase
        end
      end
    end
  end

  // Pin ownership; the held level shows as soon as the driver turns on
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      oe_reg <= '0;
    end else if (i_clk_en) begin
      for (int c = 0; c < NUM_CH; c++) begin
        oe_reg[c] <= compare[c] && els[c] != ELS_RELEASE; // R5 R16
      end
    end
  end

  always_comb begin
    regs.rdata = 8'h00;
    for (int c = 0; c < NUM_CH; c++) begin
      if (ch_of(regs.raddr) == 2'(c)) begin
        case (off_of(regs.raddr))
          OFF_STATUS_CTRL: regs.rdata = dis[c] ? 8'h00 : {flag_reg[c], sc_reg[c]};
          OFF_VALUE_HIGH:  regs.rdata = val_reg[c][15:8];
          OFF_VALUE_LOW:   regs.rdata = val_reg[c][7:0];
          default:         regs.rdata = 8'h00;
        endcase
      end
    end
  end

  assign o_channel_pin        = out_reg;
  assign o_channel_pin_oe     = oe_reg;
  assign o_channel_event_flag = flag_reg;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst || !i_clk_en);

  for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
    sequence s_max_ovf;
      ovf_act[g] && max_eff_reg[g] && els[g] == ELS_FALL_CLR;
    endsequence
    sequence s_held_high;
      out_reg[g] ##1 (out_reg[g] || !compare[g] || els[g] != ELS_FALL_CLR || ovf_act[g]);
    endsequence

    a_capture_latch: assert property (cap_hit[g] |=> val_reg[g] == $past(i_counter) && // R1
      flag_reg[g]) else $error("capture did not latch counter");
    a_toggle_cmp: assert property (match[g] && !ovf_act[g] && els[g] == ELS_RISE_TGL // R2
      |=> out_reg[g] != $past(out_reg[g])) else $error("toggle on compare missing");
    a_set_cmp: assert property (match[g] && !ovf_act[g] && els[g] == ELS_ANY_SET // R3
      |=> out_reg[g]) else $error("set on compare missing");
    a_preset_level: assert property (els[g] == ELS_RELEASE ##1 els[g] == ELS_RELEASE // R4
      |-> out_reg[g] == !$past(cfg[g][BIT_UNB])) else $error("preset level wrong");
    a_released_pin: assert property (els[g] == ELS_RELEASE || dis[g] // R5
      |=> !o_channel_pin_oe[g]) else $error("released pin still driven");
    a_ovf_wins: assert property (ovf_act[g] && match[g] && !max_eff_reg[g] // R8
      |=> out_reg[g] != $past(out_reg[g])) else $error("overflow did not win");
    a_full_duty: assert property (s_max_ovf |=> s_held_high) // R9
      else $error("full duty output dropped");
    a_cap_blocked: assert property (cap_block_reg[g] ##0 !cap_hit[g] // R12
      |=> $stable(val_reg[g]) || $past(wr_vh[g] || wr_vl[g]))
      else $error("capture passed the byte interlock");
    a_cmp_blocked: assert property (wr_vh[g] && compare[g] && !wr_vl[g] // R13
      |=> cmp_block_reg[g] && !match[g]) else $error("compare not blocked");
    a_halt_no_cap: assert property (i_counter_halt && capture[g] && !wr_vh[g] && !wr_vl[g] // R17
      |=> $stable(val_reg[g])) else $error("capture during counter halt");
  end
endmodule

// ---- common/tcc_pkg.sv ----
// Constants, register map and decode helpers of the four-channel capture/compare block.
// Assumes a byte-wide register view that is reached through 32-bit AXI4-Lite words.
package tcc_pkg;
  localparam int NUM_CH = 4;
  localparam int VAL_W  = 16;
  localparam int ADDR_W = 8;
  localparam int CH_LSB = 4;

  // Channel c sits at byte address c * 16 plus the register offset
  localparam logic [3:0] OFF_STATUS_CTRL = 4'h0;
  localparam logic [3:0] OFF_VALUE_HIGH  = 4'h4;
  localparam logic [3:0] OFF_VALUE_LOW   = 4'h8;

  // Field positions of channel_status_control
  localparam int BIT_FLAG = 7;
  localparam int BIT_IE   = 6;
  localparam int BIT_BUF  = 5;
  localparam int BIT_UNB  = 4;
  localparam int BIT_ELH  = 3;
  localparam int BIT_ELL  = 2;
  localparam int BIT_TOV  = 1;
  localparam int BIT_MAX  = 0;

  localparam logic [6:0] SC_RESET = 7'h00;

  // Edge/level select codes
  localparam logic [1:0] ELS_RELEASE  = 2'h0;
  localparam logic [1:0] ELS_RISE_TGL = 2'h1;
  localparam logic [1:0] ELS_FALL_CLR = 2'h2;
  localparam logic [1:0] ELS_ANY_SET  = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [3:0] off_of(input logic [ADDR_W-1:0] a);
    return a[CH_LSB-1:0];
  endfunction

  function automatic logic [1:0] ch_of(input logic [ADDR_W-1:0] a);
    return a[CH_LSB+1:CH_LSB];
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:CH_LSB+2] == 2'h0) &&
           (off_of(a) == OFF_STATUS_CTRL || off_of(a) == OFF_VALUE_HIGH ||
            off_of(a) == OFF_VALUE_LOW);
  endfunction
endpackage

// ---- common/tcc_reg_if.sv ----
// Byte-wide register access strobes between the bus slave and the channel core.
// Assumes one clock; strobes are single-cycle and qualified by the clock enable.
`timescale 1ns/1ps
interface tcc_reg_if;
  import tcc_pkg::*;
  logic              wr;
  logic [ADDR_W-1:0] waddr;
  logic [7:0]        wdata;
  logic              rd;
  logic [ADDR_W-1:0] raddr;
  logic [7:0]        rdata;
  modport bus  (output wr, waddr, wdata, rd, raddr, input rdata);
  modport core (input wr, waddr, wdata, rd, raddr, output rdata);
endinterface

// ---- rtl/tcc_axil_slave.sv ----
// AXI4-Lite slave that turns bus words into byte-wide register strobes.
// Assumes a master that keeps one write and one read under way at a time.
`timescale 1ns/1ps
module tcc_axil_slave
  import tcc_pkg::*;
(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_clk_en,
  // Write channels
  input  wire logic [ADDR_W-1:0] i_axi_awaddr,
  input  wire logic              i_axi_awvalid,
  output logic                   o_axi_awready,
  input  wire logic [31:0]       i_axi_wdata,
  input  wire logic [3:0]        i_axi_wstrb,
  input  wire logic              i_axi_wvalid,
  output logic                   o_axi_wready,
  output logic [1:0]             o_axi_bresp,
  output logic                   o_axi_bvalid,
  input  wire logic              i_axi_bready,
  // Read channels
  input  wire logic [ADDR_W-1:0] i_axi_araddr,
  input  wire logic              i_axi_arvalid,
  output logic                   o_axi_arready,
  output logic [31:0]            o_axi_rdata,
  output logic [1:0]             o_axi_rresp,
  output logic                   o_axi_rvalid,
  input  wire logic              i_axi_rready,
  // Register strobes
  tcc_reg_if.bus                 regs
);
  logic              aw_have_reg;
  logic              w_have_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0]        wdata_reg;
  logic              wlane_reg;
  logic              do_write;

  assign o_axi_awready = !aw_have_reg;
  assign o_axi_wready  = !w_have_reg;
  assign o_axi_arready = !o_axi_rvalid;
  assign do_write      = aw_have_reg && w_have_reg && !o_axi_bvalid;

  // Only byte lane 0 carries register bits; a write without it stores nothing
  assign regs.wr    = i_clk_en && do_write && wlane_reg && addr_ok(awaddr_reg);
  assign regs.waddr = awaddr_reg;
  assign regs.wdata = wdata_reg;
  assign regs.rd    = i_clk_en && i_axi_arvalid && o_axi_arready && addr_ok(i_axi_araddr);
  assign regs.raddr = i_axi_araddr;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      awaddr_reg   <= '0;
      wdata_reg    <= 8'h00;
      wlane_reg    <= 1'b0;
      o_axi_bvalid <= 1'b0;
      o_axi_bresp  <= RESP_OKAY;
    end else if (i_clk_en) begin
      if (i_axi_awvalid && !aw_have_reg) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= i_axi_awaddr;
      end
      if (i_axi_wvalid && !w_have_reg) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= i_axi_wdata[7:0];
        wlane_reg  <= i_axi_wstrb[0];
      end
      if (do_write) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        o_axi_bvalid <= 1'b1;
        o_axi_bresp  <= addr_ok(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (o_axi_bvalid && i_axi_bready) begin
        o_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_axi_rvalid <= 1'b0;
      o_axi_rdata  <= 32'h0000_0000;
      o_axi_rresp  <= RESP_OKAY;
    end else if (i_clk_en) begin
      if (i_axi_arvalid && o_axi_arready) begin
        o_axi_rvalid <= 1'b1;
        o_axi_rdata  <= addr_ok(i_axi_araddr) ? {24'h00_0000, regs.rdata} : 32'h0000_0000;
        o_axi_rresp  <= addr_ok(i_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (o_axi_rvalid && i_axi_rready) begin
        o_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ---- rtl/tcc_edge_detect.sv ----
// Rising and falling edge detector for one channel pin.
// Assumes the pin input is already synchronous to the system clock.
`timescale 1ns/1ps
module tcc_edge_detect (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  input  wire logic i_clk_en,
  // Pin level and edges
  input  wire logic i_level,
  output logic      o_rise,
  output logic      o_fall
);
  logic prev_reg;

  // Tracks the pin always, so a pin stable before enabling gives no false edge
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prev_reg <= 1'b0;
    end else if (i_clk_en) begin
      prev_reg <= i_level; // R14
    end
  end

  assign o_rise = i_level && !prev_reg;
  assign o_fall = !i_level && prev_reg;
endmodule

// ---- tb/tcc_pin_agent.sv ----
// Far-side model that plays the external signals on the channel pins.
// Assumes the bench resolves each wire from this level and the channel enable.
`timescale 1ns/1ps
module tcc_pin_agent (
  // Clock and request
  input  wire logic       i_sys_clk,
  input  wire logic [3:0] i_level,
  // Pin drive
  output logic      [3:0] o_pin
);
  // Moves only on a clock edge, so the level is stable between requests
  always_ff @(posedge i_sys_clk) begin
    o_pin <= i_level;
  end
endmodule

// ---- tb/timer_channel_capture_compare_tb.sv ----
// Self-checking bench for the four-channel capture/compare block.
// Assumes the pin agent plus a bench-driven counter, tick, overflow and halt.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module timer_channel_capture_compare_tb;
  import tcc_pkg::*;
  logic        sys_clk = 1'b0, nrst = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, q;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] counter = 16'h0, c1, c2, v, cmp_val;
  logic        tk = 1'b0, ovf = 1'b0, halt = 1'b0, ce = 1'b1;
  logic [3:0]  drive = 4'h0, agent_pin, pin_in, pin_out, pin_oe, flag;
  int          n_mismatch = 0, cmp_count = 0, m;

  always #5 sys_clk = ~sys_clk;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & agent_pin);

  tcc_pin_agent u_agent (.i_sys_clk(sys_clk), .i_level(drive), .o_pin(agent_pin));
  tcc_channels u_dut (
    .i_sys_clk(sys_clk), .i_nrst(nrst), .i_clk_en(ce),
    .i_axi_awaddr(awaddr), .i_axi_awvalid(awv), .o_axi_awready(awready),
    .i_axi_wdata(wdata), .i_axi_wstrb(4'hF), .i_axi_wvalid(wv), .o_axi_wready(wready),
    .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
    .i_axi_araddr(araddr), .i_axi_arvalid(arv), .o_axi_arready(arready),
    .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready),
    .i_counter(counter), .i_tclk_en(tk), .i_overflow(ovf), .i_counter_halt(halt),
    .i_channel_pin(pin_in), .o_channel_pin(pin_out), .o_channel_pin_oe(pin_oe),
    .o_channel_event_flag(flag));

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Ready is judged at the falling edge, where it equals what the next rising edge samples
  task automatic acc(input bit w, input logic [7:0] a, input logic [7:0] d);
    int n;
    bit ta, tw, tr, done;
    if (w) begin
      awaddr <= a;
      wdata <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
    end
    for (n = 0; n < 40 && !done; n++) begin
      @(negedge sys_clk);
      ta = awv && awready;
      tw = wv && wready;
      tr = arv && arready;
      done = w ? bvalid : rvalid;
      q = rdata[7:0];
      r = w ? bresp : rresp;
      @(posedge sys_clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tr) arv <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    // One idle edge, so a following call never raises a ready in the same step
    @(posedge sys_clk);
    if (!done) begin
      n_mismatch++;
      $display("wrong value t=%0t bus timeout", $time);
      summarize();
    end
  endtask

  task automatic rd16(input logic [7:0] base);
    acc(1'b0, base + 8'h04, 8'h00);
    v[15:8] = q;
    acc(1'b0, base + 8'h08, 8'h00);
    v[7:0] = q;
  endtask

  task automatic pin_edge(input logic [15:0] c, input logic lv);
    counter <= c;
    drive[0] <= lv;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic tick(input logic [15:0] c, input logic o);
    counter <= c;
    ovf <= o;
    tk <= 1'b1;
    @(posedge sys_clk);
    ovf <= 1'b0;
    tk <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  initial begin
    void'($urandom(32'h99e0));
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    `CHK(pin_out, 4'hF)
    `CHK(pin_oe, 4'h0)
    acc(1'b0, 8'h00, 8'h00);
    `CHK(q, 8'h00)
    acc(1'b0, 8'hC0, 8'h00);
    `CHK(r, RESP_SLVERR)
    $display("test reset done");
    for (int e = 1; e < 4; e++) begin
      acc(1'b0, 8'h00, 8'h00);
      acc(1'b1, 8'h00, 8'(e << 2));
      c1 = 16'($urandom);
      c2 = 16'($urandom);
      pin_edge(c1, 1'b1);
      `CHK(flag[0], 1'(e & 1))
      pin_edge(c2, 1'b0);
      rd16(8'h00);
      `CHK(v, (e == 1) ? c1 : c2)
    end
    $display("test capture done");
    halt <= 1'b1;
    pin_edge(16'h1234, 1'b1);
    halt <= 1'b0;
    rd16(8'h00);
    `CHK(v, c2)
    acc(1'b0, 8'h04, 8'h00);
    pin_edge(16'h5678, 1'b0);
    acc(1'b0, 8'h08, 8'h00);
    `CHK(q, c2[7:0])
    pin_edge(16'hABCD, 1'b1);
    rd16(8'h00);
    `CHK(v, 16'hABCD)
    $display("test capture block done");
    cmp_val = 16'($urandom) | 16'h0100;
    acc(1'b1, 8'h10, 8'h10);
    acc(1'b1, 8'h14, cmp_val[15:8]);
    acc(1'b1, 8'h18, cmp_val[7:0]);
    `CHK(pin_out[1], 1'b0)
    m = 0;
    for (int e = 1; e < 4; e++) begin
      acc(1'b1, 8'h10, 8'(8'h10 | (e << 2)));
      tick(cmp_val, 1'b0);
      m = (e == 1) ? !m : (e == 3);
      `CHK(pin_out[1], 1'(m))
      `CHK(pin_oe[1], 1'b1)
    end
    `CHK(flag[1], 1'b1)
    acc(1'b1, 8'h10, 8'h1E);
    for (int i = 0; i < 3; i++) begin
      tick((i == 2) ? cmp_val : ~cmp_val, 1'b1);
      m = !m;
      `CHK(pin_out[1], 1'(m))
    end
    acc(1'b1, 8'h10, 8'h1C);
    acc(1'b1, 8'h14, cmp_val[15:8]);
    tick(cmp_val, 1'b0);
    `CHK(pin_out[1], 1'b0)
    acc(1'b1, 8'h18, cmp_val[7:0]);
    tick(cmp_val, 1'b0);
    `CHK(pin_out[1], 1'b1)
    $display("test compare done");
    acc(1'b1, 8'h10, 8'h1B);
    tick(~cmp_val, 1'b1);
    `CHK(pin_out[1], 1'b0)
    tick(~cmp_val, 1'b1);
    tick(cmp_val, 1'b0);
    `CHK(pin_out[1], 1'b1)
    acc(1'b1, 8'h10, 8'h1A);
    tick(cmp_val, 1'b0);
    `CHK(pin_out[1], 1'b1)
    tick(~cmp_val, 1'b1);
    tick(cmp_val, 1'b0);
    `CHK(pin_out[1], 1'b0)
    $display("test max duty done");
    acc(1'b1, 8'h20, 8'h24);
    acc(1'b1, 8'h24, cmp_val[15:8]);
    acc(1'b1, 8'h28, cmp_val[7:0]);
    `CHK(r, RESP_OKAY)
    acc(1'b1, 8'h30, 8'h1C);
    acc(1'b0, 8'h30, 8'h00);
    `CHK(q, 8'h00)
    tick(cmp_val, 1'b0);
    `CHK(pin_out[2], 1'b0)
    `CHK(pin_oe[3], 1'b0)
    acc(1'b1, 8'h34, ~cmp_val[15:8]);
    acc(1'b1, 8'h38, ~cmp_val[7:0]);
    tick(~cmp_val, 1'b0);
    `CHK(pin_out[2], 1'b0)
    tick(~cmp_val, 1'b1);
    tick(~cmp_val, 1'b0);
    `CHK(pin_out[2], 1'b1)
    `CHK(flag[2], 1'b1)
    ce <= 1'b0;
    tick(~cmp_val, 1'b0);
    ce <= 1'b1;
    `CHK(pin_out[2], 1'b1)
    $display("test buffered done");
    summarize();
  end
endmodule
